// ===== core/qeo_top.sv
// quadrature output, index pin and index programming sequence
// Operation
// - one 5.625 degree step toggles exactly one channel
// - each channel toggles every 11.25 degrees
// - sixteen pulses per channel, 64 positions per revolution
// - output frequency at most 8 kHz; decoder must follow
// - clockwise: channel A leads B by one step
// - counter-clockwise: channel B leads A
// - select low: measure and drive both channels
// - select high: power-down, both channels high impedance
// - rising select edge latches present position; the code skips this while an index is live
// - first programming pulse after wait enters programming mode
// - seven following pulses write latched position to OTP
// - ninth pulse sets permanent index enable flag
// - new index appears only after a power cycle
// - programmed index gives one pulse per revolution; the code drives index only while select is high, with position held
// - programming pin is the only OTP write path
`timescale 1ns/1ps
module qeo_top
  import qeo_pkg::*;
(
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic [POS_W-1:0] sensed_pos_in,
  input  wire logic             chip_select_n_in,
  input  wire logic             otp_write_pin_in,
  output logic                  chan_a_out,
  output logic                  chan_b_out,
  output logic                  chan_a_oe_out,
  output logic                  chan_b_oe_out,
  output logic                  index_out,
  output logic                  index_oe_out,
  output logic                  ready_out
);
  // whole block state; one copy is built each cycle and registered
  typedef struct packed {
    // position tracking and power-on setup
    logic [POS_W-1:0] pos;      // tracked output position
    logic [15:0]      step_cnt; // rate limiter
    logic [15:0]      setup_cnt;
    logic             ready;
    // pin history for edge detection
    logic             cs_n;
    logic             otp_write_pin_pin;
    // programming sequence
    logic [POS_W-1:0] latched;
    qeo_otp_write_pin_t        pstate;
    logic [15:0]      pcnt;     // wait / pulse length counter
    logic [3:0]       pulses;
    logic             wr_pos;
    logic             wr_en;
    // fuse copy taken once after power-on
    logic             idx_live;  // enable sampled at power-on
    logic             idx_seen;
    logic [POS_W-1:0] live_ref;
    // registered pin levels and enables
    logic             a;
    logic             b;
    logic             a_oe;
    logic             b_oe;
    logic             idx;
    logic             idx_oe;
  } qeo_st_t;

  qeo_st_t          st_q, st_d;
  logic [POS_W-1:0] otp_ref;
  logic             otp_en;

  // fuse store; written only by the programming sequence below
  qeo_otp u_otp (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .wr_pos_in  (st_q.wr_pos),
    .wr_en_in   (st_q.wr_en),
    .pos_in     (st_q.latched),
    .ref_out    (otp_ref),
    .idx_en_out (otp_en)
  );

  // next-state logic for the whole block
  always_comb begin
    // locals: position gap and pin edges
    logic [POS_W-1:0] diff;
    logic             rise_cs;
    logic             fall_pg;
    st_d     = st_q;
    diff     = sensed_pos_in - st_q.pos;
    rise_cs  = chip_select_n_in && !st_q.cs_n;
    fall_pg  = !otp_write_pin_in && st_q.otp_write_pin_pin;
    st_d.cs_n     = chip_select_n_in;
    st_d.otp_write_pin_pin = otp_write_pin_in;
    st_d.wr_pos   = 1'b0;
    st_d.wr_en    = 1'b0;
    // copy the fuses once, on the first edge after power-on; a fuse
    // burned later stays invisible until the next power cycle
    if (!st_q.idx_seen) begin
      st_d.idx_live = otp_en;
      st_d.live_ref = otp_ref;
      st_d.idx_seen = 1'b1;
    end
    // power-on setup time before outputs are driven as valid
    if (st_q.setup_cnt != 16'(SETUP_CYC)) begin
      st_d.setup_cnt = st_q.setup_cnt + 16'h0001;
    end else begin
      st_d.ready = 1'b1;
    end
    // step the tracked position one increment at a time, rate-limited;
    // a magnet turning faster than the limit is followed late, never skipped
    if (st_q.step_cnt != 16'h0000) begin
      st_d.step_cnt = st_q.step_cnt - 16'h0001;
    end else if (!chip_select_n_in && st_q.ready && diff != 6'h00) begin
      st_d.step_cnt = 16'(STEP_CYC - 1);
      // the shorter way round decides the direction
      if (!diff[POS_W-1]) begin
        st_d.pos = st_q.pos + 6'h01;
      end else begin
        st_d.pos = st_q.pos - 6'h01;
      end
    end
    // gray code of position bits 1:0; counting up (clockwise) moves A first
    st_d.a = st_d.pos[1] ^ st_d.pos[0];
    st_d.b = st_d.pos[1];
    // both channels float while deselected or before setup ends
    st_d.a_oe = !chip_select_n_in && st_d.ready;
    st_d.b_oe = !chip_select_n_in && st_d.ready;
    // index: shared pin, driven only while select is released and enabled
    st_d.idx    = st_q.idx_live && (st_d.pos == st_q.live_ref);
    st_d.idx_oe = st_q.idx_live && chip_select_n_in && st_d.ready
                  && (st_q.pstate == QEO_IDLE);
    // programming sequence; a part with a live index never restarts it, so
    // its index driver cannot fight a station holding the select pin
    case (st_q.pstate)
      // measurement or power-down; a select release latches the position unless an index is live
      QEO_IDLE: begin
        if (rise_cs && !st_q.idx_live) begin
          st_d.latched = st_q.pos;
          st_d.pcnt    = 16'h0000;
          st_d.pstate  = QEO_WAIT;
        end
      end
      // minimum wait after the latching edge
      QEO_WAIT: begin
        if (!chip_select_n_in) begin
          st_d.pstate = QEO_IDLE;
        end else if (st_q.pcnt == 16'(WAIT_CYC - 1)) begin
          st_d.pstate = QEO_ARMED;
        end else begin
          st_d.pcnt = st_q.pcnt + 16'h0001;
        end
      end
      // entry pulse high time is counted on top of the wait count
      QEO_ARMED: begin
        if (!chip_select_n_in) begin
          st_d.pstate = QEO_IDLE;
        end else if (otp_write_pin_in) begin
          if (st_q.pcnt != 16'hFFFF) begin
            st_d.pcnt = st_q.pcnt + 16'h0001;
          end
        end else if (fall_pg) begin
          // a short entry pulse ends the sequence; select low restarts it
          if (st_q.pcnt >= 16'(WAIT_CYC - 1 + PROGEN_CYC)) begin
            st_d.pstate = QEO_OTP_WRITE_PIN;
            st_d.pulses = 4'h1;
          end else begin
            st_d.pstate = QEO_DONE;
          end
        end
      end
      // pulses counted on their falling edge; entry pulse is number one
      QEO_OTP_WRITE_PIN: begin
        if (!chip_select_n_in) begin
          st_d.pstate = QEO_IDLE;
        end else if (fall_pg) begin
          // pulses 2 to 8 carry data; the write lands at the fall of pulse 8
          st_d.pulses = st_q.pulses + 4'h1;
          if (st_q.pulses == 4'(DATA_PULSES)) begin
            st_d.wr_pos = 1'b1;
          end
          if (st_q.pulses == 4'(PULSE_ENABLE - 1)) begin
            st_d.wr_en  = 1'b1;
            st_d.pstate = QEO_DONE;
          end
        end
      end
      // finished or refused; waits for select low
      QEO_DONE: begin
        if (!chip_select_n_in) begin
          st_d.pstate = QEO_IDLE;
        end
      end
      default: st_d.pstate = QEO_IDLE;
    endcase
  end

  // state register; reset stands for power-on, sampling the fuses afterwards
  // reset clears tracking and sequence, never the fuses inside the store
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_q          <= '0;
      st_q.pstate   <= QEO_IDLE;
      st_q.cs_n     <= 1'b1; // select idles high, so no false edge
      st_q.idx_seen <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // every output comes straight from the registered state
  assign chan_a_out    = st_q.a;
  assign chan_b_out    = st_q.b;
  assign chan_a_oe_out = st_q.a_oe;
  assign chan_b_oe_out = st_q.b_oe;
  assign index_out     = st_q.idx;
  assign index_oe_out  = st_q.idx_oe;
  assign ready_out     = st_q.ready;
endmodule // qeo_top

// ===== core/qeo_pkg.sv
// package of constants and types for the quadrature encoder output block
package qeo_pkg;
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned POS_W          = 6;            // 64 positions
  localparam int unsigned POS_STEPS      = 64;
  localparam int unsigned MAX_OUT_HZ     = 8000;         // highest channel frequency
  // least time between two position steps: one quarter period at highest rate
  localparam int unsigned STEP_CYC       = CLK_HZ / (MAX_OUT_HZ * 4);
  localparam real         WAIT_US        = 0.5;          // wait after latching edge
  localparam int unsigned WAIT_CYC       = 20;           // ceil(0.5us * 40 MHz)
  localparam int unsigned PROGEN_US      = 200;          // mode entry pulse length
  localparam int unsigned PROGEN_CYC     = PROGEN_US * (CLK_HZ / 1000000);
  localparam int unsigned SETUP_US       = 20;           // power-on setup
  localparam int unsigned SETUP_CYC      = SETUP_US * (CLK_HZ / 1000000);
  localparam int unsigned DATA_PULSES    = 7;
  localparam int unsigned PULSE_ENABLE   = 9;            // pulse that sets index enable
  localparam logic [5:0]  POS_RST        = 6'h00;
  localparam logic [15:0] CNT_RST        = 16'h0000;
  localparam logic [3:0]  PCNT_RST       = 4'h0;

  typedef enum logic [4:0] {
    QEO_IDLE  = 5'h01,   // measurement or power-down, no sequence
    QEO_WAIT  = 5'h02,   // latched, waiting minimum time
    QEO_ARMED = 5'h04,   // may take the entry pulse
    QEO_OTP_WRITE_PIN  = 5'h08,   // programming mode, counting pulses
    QEO_DONE  = 5'h10    // sequence finished or aborted
  } qeo_otp_write_pin_t;
endpackage : qeo_pkg

// ===== core/qeo_otp.sv
// one-time-programmable index store written only through the programming pin
`timescale 1ns/1ps
module qeo_otp
  import qeo_pkg::*;
(
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic             wr_pos_in,
  input  wire logic             wr_en_in,
  input  wire logic [POS_W-1:0] pos_in,
  output logic      [POS_W-1:0] ref_out,
  output logic                  idx_en_out
);
  typedef struct packed {
    logic [POS_W-1:0] ref_pos;
    logic             pos_done;
    logic             en;
  } qeo_otp_st_t;

  // blank fuses read as zero until burned
  qeo_otp_st_t st_q = '0;
  qeo_otp_st_t st_d;

  // fuses set once, never cleared; power cycle does not clear them
  always_comb begin
    st_d = st_q;
    if (wr_pos_in && !st_q.pos_done && !rst_in) begin
      st_d.ref_pos  = pos_in;
      st_d.pos_done = 1'b1;
    end
    if (wr_en_in && !rst_in) begin
      st_d.en = 1'b1;
    end
  end

  // fuse contents model non-volatile storage; reset leaves them
  always_ff @(posedge ref_clk_in) begin
    st_q <= st_d;
  end

  assign ref_out    = st_q.ref_pos;
  assign idx_en_out = st_q.en;
endmodule // qeo_otp

// ===== sim/qeo_monitor.sv
// checker of channel, select, index pin and ready timing at the ports
`timescale 1ns/1ps
module qeo_monitor
  import qeo_pkg::*;
(
  input wire logic             ref_clk_in,
  input wire logic             rst_in,
  input wire logic [POS_W-1:0] sensed_pos_in,
  input wire logic             chip_select_n_in,
  input wire logic             otp_write_pin_in,
  input wire logic             chan_a_out,
  input wire logic             chan_b_out,
  input wire logic             chan_a_oe_out,
  input wire logic             chan_b_oe_out,
  input wire logic             index_out,
  input wire logic             index_oe_out,
  input wire logic             ready_out
);
  logic [15:0] gap_q;
  logic [15:0] up_q;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // cycles since last channel edge and since reset release
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      gap_q <= 16'hFFFF;
      up_q  <= 16'h0000;
    end else begin
      if ($changed({chan_a_out, chan_b_out})) gap_q <= 16'h0000;
      else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
      if (up_q != 16'hFFFF) up_q <= up_q + 16'h0001;
    end
  end
  // select held high over two edges
  sequence sel_held;
    chip_select_n_in ##1 chip_select_n_in;
  endsequence
  one_channel_a: assert property (!($changed(chan_a_out) && $changed(chan_b_out)))
    else $error("both channels changed together");
  sel_drive_a: assert property (!chip_select_n_in && ready_out
    |=> chan_a_oe_out && chan_b_oe_out)
    else $error("channels not driven while selected");
  sel_float_a: assert property (sel_held |-> !chan_a_oe_out && !chan_b_oe_out)
    else $error("channels driven while deselected");
  sel_freeze_a: assert property (sel_held |-> $stable({chan_a_out, chan_b_out}))
    else $error("channels moved while deselected");
  step_gap_a: assert property ($changed({chan_a_out, chan_b_out}) |-> gap_q >= STEP_CYC - 2)
    else $error("channel edges too close");
  ready_hold_a: assert property (!$past(ready_out) |-> $stable({chan_a_out, chan_b_out}))
    else $error("channels moved before ready");
  ready_time_a: assert property (ready_out |-> up_q >= SETUP_CYC - 2)
    else $error("ready too early");
  ready_rise_a: assert property ($rose(ready_out) |-> up_q == 16'(SETUP_CYC + 1))
    else $error("ready at wrong cycle");
  index_shared_a: assert property (!chip_select_n_in |=> !index_oe_out)
    else $error("index driven while select low");
endmodule // qeo_monitor

// ===== sim/qeo_decoder.sv
// quadrature decoder model counting every channel edge
`timescale 1ns/1ps
module qeo_decoder (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         a_in,
  input  wire logic         b_in,
  input  wire logic         en_in,
  output logic signed [7:0] count_out
);
  logic [1:0] ph_q;
  // phase index counts up when A changes first (clockwise)
  wire  [1:0] ph = {b_in, a_in ^ b_in};
  // sampled every clock so the highest channel rate is followed
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ph_q      <= 2'h0;
      count_out <= 8'sh00;
    end else if (en_in) begin
      if (ph == ph_q + 2'h1) count_out <= count_out + 8'sh01;
      if (ph == ph_q - 2'h1) count_out <= count_out - 8'sh01;
      ph_q <= ph;
    end
  end
endmodule // qeo_decoder

// ===== sim/tb_quadrature_encoder_index_otp.sv
// testbench: channel stepping, select, index programming
`timescale 1ns/1ps
module tb_quadrature_encoder_index_otp;
  import qeo_pkg::*;
  logic             ref_clk_in = 1'b0;
  logic             rst_in = 1'b1;
  logic             chip_select_n_in = 1'b1;
  logic             otp_write_pin_in = 1'b0;
  logic [POS_W-1:0] sensed_pos_in = 6'h00;
  logic chan_a_out, chan_b_out, chan_a_oe_out, chan_b_oe_out;
  logic index_out, index_oe_out, ready_out;
  logic signed [7:0] count;
  int n_errors = 0;
  int checks_done = 0;
  // released line is pulled high
  wire a_w = chan_a_oe_out ? chan_a_out : 1'b1;
  wire b_w = chan_b_oe_out ? chan_b_out : 1'b1;
  always #12.5 ref_clk_in = ~ref_clk_in;
  qeo_top dut (.ref_clk_in, .rst_in, .sensed_pos_in, .chip_select_n_in, .otp_write_pin_in,
    .chan_a_out, .chan_b_out, .chan_a_oe_out, .chan_b_oe_out, .index_out, .index_oe_out,
    .ready_out);
  qeo_decoder dec (.clk_in(ref_clk_in), .rst_in(rst_in), .a_in(a_w), .b_in(b_w),
    .en_in(chan_a_oe_out & chan_b_oe_out), .count_out(count));
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected {A, B} per position: counting up makes A change first
  function automatic logic [1:0] qexp(input logic [5:0] p);
    case (p[1:0])
      2'h0:    qexp = 2'h0;
      2'h1:    qexp = 2'h2;
      2'h2:    qexp = 2'h3;
      default: qexp = 2'h1;
    endcase
  endfunction
  task automatic results;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // power cycle, then wait out the setup time
  task automatic power;
    rst_in <= 1'b1;
    cyc(5);
    rst_in <= 1'b0;
    cyc(SETUP_CYC + 5);
    chk(8'(ready_out), 8'h01);
  endtask
  // move to position p, wait out n steps and compare channel levels
  task automatic move(input logic [5:0] p, input int n);
    sensed_pos_in <= p;
    cyc(n * STEP_CYC + 20);
    chk(8'({chan_a_out, chan_b_out}), 8'(qexp(p)));
  endtask
  // four steps up, five down across the wrap
  task automatic scen_turn;
    chip_select_n_in <= 1'b0;
    for (int i = 1; i <= 4; i++) move(6'(i), 1);
    chk(count, 8'h04);
    for (int i = 3; i >= -1; i--) move(6'(i), 1);
    chk(count, 8'hFF);
  endtask
  // latch position 5 and run the pulse sequence
  task automatic scen_otp_write_pin;
    move(6'h05, 6);
    chk(count, 8'h05);
    chip_select_n_in <= 1'b1;
    cyc(WAIT_CYC + 5);
    chk(8'({chan_a_oe_out, chan_b_oe_out}), 8'h00);
    sensed_pos_in <= 6'h09;
    otp_write_pin_in <= 1'b1;
    cyc(PROGEN_CYC + 10);
    otp_write_pin_in <= 1'b0;
    repeat (8) begin
      cyc(200);
      otp_write_pin_in <= 1'b1;
      cyc(200);
      otp_write_pin_in <= 1'b0;
    end
    cyc(10);
    chk(8'({chan_a_out, chan_b_out}), 8'(qexp(6'h05)));
    chk(8'(index_oe_out), 8'h00);
  endtask
  // after power cycle the index shows at position 5 only
  task automatic scen_index;
    power;
    chk(8'(index_oe_out), 8'h01);
    chip_select_n_in <= 1'b0;
    move(6'h05, 6);
    chk(count, 8'h05);
    chip_select_n_in <= 1'b1;
    cyc(3);
    chk(8'({index_oe_out, index_out}), 8'h03);
    chip_select_n_in <= 1'b0;
    move(6'h06, 1);
    chk(count, 8'h06);
    chip_select_n_in <= 1'b1;
    cyc(3);
    chk(8'({index_oe_out, index_out}), 8'h02);
  endtask
  initial begin
    power;
    chk(8'({chan_a_oe_out, chan_b_oe_out, index_oe_out}), 8'h00);
    scen_turn;
    scen_otp_write_pin;
    scen_index;
    results;
  end
  // hang guard
  initial begin
    cyc(70000);
    n_errors++;
    results;
  end
endmodule // tb_quadrature_encoder_index_otp
bind qeo_top qeo_monitor mon (.ref_clk_in, .rst_in, .sensed_pos_in, .chip_select_n_in,
  .otp_write_pin_in, .chan_a_out, .chan_b_out, .chan_a_oe_out, .chan_b_oe_out, .index_out,
  .index_oe_out, .ready_out);
